// >>> design/tach_cfg_pkg.sv
package tach_cfg_pkg;
  // register byte addresses and power-on values
  localparam logic [7:0] PULSE_CFG_ADDR = 8'h78;
  localparam logic [7:0] TEST_FIRST_ADDR = 8'h7e;
  localparam logic [7:0] TEST_SECOND_ADDR = 8'h7f;
  localparam logic [7:0] PULSE_CFG_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field layout of the pulse-count register
  localparam int FAN_CHANNELS = 4;
  localparam int SEL_W = 2;
  localparam int FIRST_SEL_LSB = 0;
  localparam int SECOND_SEL_LSB = 2;
  localparam int THIRD_SEL_LSB = 4;
  localparam int FOURTH_SEL_LSB = 6;

  // measurement timing
  localparam int CLK_HZ = 25_000_000;
  localparam int NORMAL_PERIOD_MS = 1000;
  localparam int FAST_PERIOD_MS = 250;
  localparam int NORMAL_CYCLES = CLK_HZ / 1000 * NORMAL_PERIOD_MS;
  localparam int FAST_CYCLES = CLK_HZ / 1000 * FAST_PERIOD_MS;
  localparam int TIMER_W = 25;
  localparam int PERIOD_W = 24;
  localparam int EDGE_W = 3;

  typedef enum logic [2:0] {
    WIN_IDLE = 3'b001,
    WIN_ARMED = 3'b010,
    WIN_COUNT = 3'b100
  } win_state_t;

  // field code 00..11 means one to four pulses
  function automatic logic [EDGE_W-1:0] pulses_needed(
    input logic [SEL_W-1:0] sel
  );
    pulses_needed = {1'b0, sel} + 3'h1;
  endfunction : pulses_needed
endpackage : tach_cfg_pkg

// >>> design/tach_win_if.sv
`timescale 1ns/1ns
interface tach_win_if;
  import tach_cfg_pkg::*;
  logic [SEL_W-1:0] sel;
  logic start;
  logic tach_edge;
  logic done;
  logic [PERIOD_W-1:0] period;
  modport ctrl (output sel, output start, output tach_edge,
                input done, input period);
  modport win (input sel, input start, input tach_edge,
               output done, output period);
endinterface : tach_win_if

// >>> design/tach_window.sv
`timescale 1ns/1ns
module tach_window
  import tach_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  tach_win_if.win link
);
  win_state_t state;
  logic [SEL_W-1:0] held_sel;
  logic [EDGE_W-1:0] edges_seen;
  logic [PERIOD_W-1:0] cycles;
  logic [PERIOD_W-1:0] period;
  logic done;
  wire [EDGE_W-1:0] next_edges = edges_seen + 3'h1;
  wire last_edge = (state == WIN_COUNT) && link.tach_edge &&
                   (next_edges == pulses_needed(held_sel));
  wire cycles_full = &cycles;

  assign link.done = done;
  assign link.period = period;

  ////////////////////////////////////////////////////////////////////////
  // window: arm on start, open on first edge, close after n more edges;
  // the select is held at arming so a write mid-window cannot skew it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WIN_IDLE;
      held_sel <= '0;
      edges_seen <= '0;
      cycles <= '0;
      period <= '0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!cycles_full) cycles <= cycles + 24'h1; // saturates on stall
      case (state)
        WIN_IDLE, WIN_ARMED: begin
          if (link.start) begin
            state <= WIN_ARMED;
            held_sel <= link.sel;
          end else if (state == WIN_ARMED && link.tach_edge) begin
            state <= WIN_COUNT;
            edges_seen <= '0;
            cycles <= '0;
          end
        end
        WIN_COUNT: begin
          if (link.start) begin
            state <= WIN_ARMED; // late window abandoned, no result
            held_sel <= link.sel;
          end else if (last_edge) begin
            state <= WIN_IDLE;
            period <= cycles;
            done <= 1'b1;
          end else if (link.tach_edge) begin
            edges_seen <= next_edges;
          end
        end
        default: state <= WIN_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_window_close;
    @(posedge clk) disable iff (!rst_n)
      (ce && last_edge && !link.start) |=> done && state == WIN_IDLE;
  endproperty
  a_window_close: assert property (p_window_close)
    else $error("window did not close on the selected pulse");

  property p_no_early_done;
    @(posedge clk) disable iff (!rst_n)
      (done && $past(ce)) |->
        $past(state) == WIN_COUNT && $past(link.tach_edge);
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("result given without a closing pulse");

  c_window_done: cover property (@(posedge clk) disable iff (!rst_n)
    done && held_sel == 2'h3);
endmodule : tach_window

// >>> design/tach_pulse_count_config.sv
`timescale 1ns/1ns
// Contract
// - lock makes pulse-count register ignore writes
// - bits 1:0 give first channel pulse count
// - bits 3:2 give second channel pulse count
// - bits 5:4 give third channel pulse count
// - bits 7:6 give fourth channel pulse count
// - pulse-count register resets to 00h
// - lock blocks writes to both test registers
// - test registers reset to 00h
// - measure once a second, fast mode 250 ms
module tach_pulse_count_config
  import tach_cfg_pkg::*;
#(
  parameter logic [TIMER_W-1:0] NORMAL_COUNT = TIMER_W'(NORMAL_CYCLES),
  parameter logic [TIMER_W-1:0] FAST_COUNT = TIMER_W'(FAST_CYCLES)
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic config_lock,
  input wire logic fast_measure,
  input wire logic [FAN_CHANNELS-1:0] tach,
  output logic [FAN_CHANNELS*PERIOD_W-1:0] tach_period,
  output logic [FAN_CHANNELS-1:0] tach_valid,
  output logic meas_start
);
  logic [7:0] pulse_cfg;
  logic [7:0] test_first;
  logic [7:0] test_second;
  logic [TIMER_W-1:0] timer;
  logic [FAN_CHANNELS-1:0] tach_prev;

  ////////////////////////////////////////////////////////////////////////
  // address decode; the lock gates every write strobe here
  wire hit_cfg = (reg_addr == PULSE_CFG_ADDR);
  wire hit_t1 = (reg_addr == TEST_FIRST_ADDR);
  wire hit_t2 = (reg_addr == TEST_SECOND_ADDR);
  wire wr_ok = reg_wr && !config_lock;
  wire wr_cfg = wr_ok && hit_cfg;
  wire wr_t1 = wr_ok && hit_t1;
  wire wr_t2 = wr_ok && hit_t2;
  wire [7:0] read_mux = hit_cfg ? pulse_cfg :
                        hit_t1 ? test_first :
                        hit_t2 ? test_second : UNMAPPED_READ;

  // per-channel field slices
  wire [SEL_W-1:0] first_tach_pulse_count =
    pulse_cfg[FIRST_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] second_tach_pulse_count =
    pulse_cfg[SECOND_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] third_tach_pulse_count =
    pulse_cfg[THIRD_SEL_LSB +: SEL_W];
  wire [SEL_W-1:0] fourth_tach_pulse_count =
    pulse_cfg[FOURTH_SEL_LSB +: SEL_W];
  wire [FAN_CHANNELS*SEL_W-1:0] sel_bus = {fourth_tach_pulse_count,
    third_tach_pulse_count, second_tach_pulse_count,
    first_tach_pulse_count};

  // measurement cadence; switching rate takes effect at next wrap
  wire [TIMER_W-1:0] reload = fast_measure ? FAST_COUNT : NORMAL_COUNT;
  wire timer_wrap = (timer == '0);
  wire [FAN_CHANNELS-1:0] tach_rise = tach & ~tach_prev;

  ////////////////////////////////////////////////////////////////////////
  // register bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cfg <= PULSE_CFG_RESET;
      test_first <= TEST_RESET;
      test_second <= TEST_RESET;
    end else if (ce) begin
      if (wr_cfg) pulse_cfg <= reg_wdata;
      if (wr_t1) test_first <= reg_wdata;
      if (wr_t2) test_second <= reg_wdata;
    end
  end

  // read data is registered one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= UNMAPPED_READ;
    else if (ce && reg_rd) reg_rdata <= read_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // interval timer and tach edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= '0;
      meas_start <= 1'b0;
      tach_prev <= '0;
    end else if (ce) begin
      timer <= timer_wrap ? reload - 25'h1 : timer - 25'h1;
      meas_start <= timer_wrap;
      tach_prev <= tach;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one measurement window per fan channel; results are gathered on nets
  // so that a single process below owns each output vector
  wire [FAN_CHANNELS-1:0] win_done;
  wire [FAN_CHANNELS*PERIOD_W-1:0] next_period;
  for (genvar i = 0; i < FAN_CHANNELS; i++) begin : g_fan
    tach_win_if link ();
    assign link.sel = sel_bus[i*SEL_W +: SEL_W];
    assign link.start = meas_start;
    assign link.tach_edge = tach_rise[i];
    tach_window u_win (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .link(link.win)
    );
    assign win_done[i] = link.done;
    // a channel keeps its last period until its window closes again
    assign next_period[i*PERIOD_W +: PERIOD_W] =
      link.done ? link.period : tach_period[i*PERIOD_W +: PERIOD_W];
  end

  // result flops: valid is a one-cycle echo of the window's done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tach_period <= '0;
      tach_valid <= '0;
    end else if (ce) begin
      tach_period <= next_period;
      tach_valid <= win_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_cfg_locked;
    @(posedge clk) disable iff (!rst_n)
      (config_lock && reg_wr && hit_cfg) |=> $stable(pulse_cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked)
    else $error("locked pulse-count register changed");

  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n)
      (ce && !config_lock && reg_wr && hit_cfg) |=>
        pulse_cfg == $past(reg_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("unlocked pulse-count write lost");

  property p_test_locked;
    @(posedge clk) disable iff (!rst_n)
      (config_lock && reg_wr) |=>
        $stable(test_first) && $stable(test_second);
  endproperty
  a_test_locked: assert property (p_test_locked)
    else $error("locked test register changed");

  property p_first_field;
    @(posedge clk) disable iff (!rst_n)
      g_fan[0].link.sel == pulse_cfg[1:0];
  endproperty
  a_first_field: assert property (p_first_field)
    else $error("first channel select mismatch");

  property p_second_field;
    @(posedge clk) disable iff (!rst_n)
      g_fan[1].link.sel == pulse_cfg[3:2];
  endproperty
  a_second_field: assert property (p_second_field)
    else $error("second channel select mismatch");

  property p_third_field;
    @(posedge clk) disable iff (!rst_n)
      g_fan[2].link.sel == pulse_cfg[5:4];
  endproperty
  a_third_field: assert property (p_third_field)
    else $error("third channel select mismatch");

  property p_fourth_field;
    @(posedge clk) disable iff (!rst_n)
      g_fan[3].link.sel == pulse_cfg[7:6];
  endproperty
  a_fourth_field: assert property (p_fourth_field)
    else $error("fourth channel select mismatch");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      (ce && timer_wrap) |=>
        timer == $past(reload) - 25'h1 && meas_start;
  endproperty
  a_reload: assert property (p_reload)
    else $error("interval timer reloaded wrongly");

  property p_test_read;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && hit_t1) |=> reg_rdata == $past(test_first);
  endproperty
  a_test_read: assert property (p_test_read)
    else $error("test register read wrong");

  // reset values are checked without a disable so reset itself is seen
  property p_cfg_reset;
    @(posedge clk) !rst_n |=> pulse_cfg == PULSE_CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("pulse-count register not at reset value");

  property p_test_reset;
    @(posedge clk) !rst_n |=>
      test_first == TEST_RESET && test_second == TEST_RESET;
  endproperty
  a_test_reset: assert property (p_test_reset)
    else $error("test register not at reset value");

  property p_test_write;
    @(posedge clk) disable iff (!rst_n)
      (ce && !config_lock && reg_wr && hit_t2) |=>
        test_second == $past(reg_wdata);
  endproperty
  a_test_write: assert property (p_test_write)
    else $error("unlocked test register write lost");

  property p_cfg_read;
    @(posedge clk) disable iff (!rst_n)
      (ce && reg_rd && hit_cfg) |=> reg_rdata == $past(pulse_cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("pulse-count register read wrong");

  c_locked_write: cover property (@(posedge clk) disable iff (!rst_n)
    config_lock && reg_wr && hit_cfg);
  c_fast_start: cover property (@(posedge clk) disable iff (!rst_n)
    fast_measure && meas_start);
  c_valid: cover property (@(posedge clk) disable iff (!rst_n)
    tach_valid[0]);
endmodule : tach_pulse_count_config

// >>> tb/test_tach_pulse_count_config.sv
`timescale 1ns/1ns
module test_tach_pulse_count_config;
  import tach_cfg_pkg::*;
  // short cadences keep the run brief but leave room for a 4-pulse window
  localparam logic [24:0] NCNT = 25'h00000c8;
  localparam logic [24:0] FCNT = 25'h0000032;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic config_lock = 1'b0;
  logic fast_measure = 1'b0;
  logic [3:0] tach = 4'h0;
  logic [FAN_CHANNELS*PERIOD_W-1:0] tach_period;
  logic [3:0] tach_valid;
  logic meas_start;
  logic [23:0] cap [4];
  logic [3:0] cap_seen = 4'h0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  tach_pulse_count_config #(.NORMAL_COUNT(NCNT), .FAST_COUNT(FCNT))
    u_tach_pulse_count_config (.clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_lock(config_lock),
    .fast_measure(fast_measure), .tach(tach), .tach_period(tach_period),
    .tach_valid(tach_valid), .meas_start(meas_start));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  // keep the first result of each channel; later windows would overwrite it.
  // sampled mid-cycle so the registered outputs have settled
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (tach_valid[i] === 1'b1 && !cap_seen[i]) begin
        cap[i] <= tach_period[24*i +: 24];
        cap_seen[i] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // inputs always move 2 ns after the rising edge
  task automatic cyc();
    @(posedge clk);
    #2;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc();
    reg_wr = 1'b0;
    // one idle edge so a following call never re-raises a strobe at once
    cyc();
  endtask : wr

  // registered read: data stands right after the edge that took the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc();
    reg_rd = 1'b0;
    d = reg_rdata;
    cyc();
  endtask : rd

  task automatic wait_start();
    for (int n = 0; n < 1000 && meas_start !== 1'b1; n++) cyc();
    cyc();
  endtask : wait_start

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic regs_test();
    logic [7:0] d;
    rd(PULSE_CFG_ADDR, d);
    check(24'(d), 24'h00);
    rd(TEST_FIRST_ADDR, d);
    check(24'(d), 24'h00);
    rd(TEST_SECOND_ADDR, d);
    check(24'(d), 24'h00);
    // unmapped addresses read as zero
    rd(8'h79, d);
    check(24'(d), 24'h00);
    wr(PULSE_CFG_ADDR, 8'h1b);
    wr(TEST_FIRST_ADDR, 8'ha5);
    wr(TEST_SECOND_ADDR, 8'h5a);
    rd(PULSE_CFG_ADDR, d);
    check(24'(d), 24'h1b);
    // a frozen clock enable must swallow the write
    ce = 1'b0;
    wr(PULSE_CFG_ADDR, 8'h33);
    ce = 1'b1;
    rd(PULSE_CFG_ADDR, d);
    check(24'(d), 24'h1b);
    config_lock = 1'b1;
    wr(PULSE_CFG_ADDR, 8'hff);
    wr(TEST_FIRST_ADDR, 8'h00);
    wr(TEST_SECOND_ADDR, 8'hff);
    rd(PULSE_CFG_ADDR, d);
    check(24'(d), 24'h1b);
    rd(TEST_FIRST_ADDR, d);
    check(24'(d), 24'ha5);
    rd(TEST_SECOND_ADDR, d);
    check(24'(d), 24'h5a);
    // test registers go back to their power-on value before normal use
    config_lock = 1'b0;
    wr(TEST_FIRST_ADDR, 8'h00);
    wr(TEST_SECOND_ADDR, 8'h00);
    rd(TEST_FIRST_ADDR, d);
    check(24'(d), 24'h00);
    rd(TEST_SECOND_ADDR, d);
    check(24'(d), 24'h00);
  endtask : regs_test

  // each channel gets its own code; rises every 8 cycles on all four
  task automatic tach_test();
    wr(PULSE_CFG_ADDR, 8'he4);
    cap_seen = 4'h0;
    wait_start();
    cyc();
    for (int p = 0; p < 7; p++) begin
      tach = 4'hf;
      repeat (4) cyc();
      tach = 4'h0;
      repeat (4) cyc();
    end
    for (int i = 0; i < 4; i++) check(24'(cap_seen[i]), 24'h1);
    check(cap[0], 24'h000007);
    check(cap[1], 24'h00000f);
    check(cap[2], 24'h000017);
    check(cap[3], 24'h00001f);
  endtask : tach_test

  task automatic cadence(input logic [24:0] exp);
    int n;
    wait_start();
    n = 1;
    while (n < 1000 && meas_start !== 1'b1) begin
      cyc();
      n++;
    end
    check(24'(n), 24'(exp));
  endtask : cadence

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #2;
    rst_n = 1'b1;
    regs_test();
    tach_test();
    cadence(NCNT);
    fast_measure = 1'b1;
    wait_start();
    cadence(FCNT);
    tally_and_finish();
  end
endmodule : test_tach_pulse_count_config
